// >>> verilog/dmc_params.svh
// timing, layout and count constants for the dram host controller
// assumes a 50 MHz clock; cycle counts are derived from their times, except sync latency, page margin and wake cycles
`ifndef DMC_PARAMS_SVH
`define DMC_PARAMS_SVH

`define DMC_CLK_NS 20
`define DMC_T_RC_NS 150
`define DMC_T_RP_NS 60
`define DMC_T_CAC_NS 40
`define DMC_T_CP_NS 25
`define DMC_T_RAS_MAX_NS 10000
`define DMC_T_REF_NS 4000000
`define DMC_T_PWRUP_NS 100000
`define DMC_REF_ROWS 256
`define DMC_WAKE_CYCLES 8
`define DMC_SYNC_LAT 4
`define DMC_PAGE_MARGIN 32

`define DMC_CEIL(t) (((t) + `DMC_CLK_NS - 1) / `DMC_CLK_NS)
`define DMC_RP_CYC `DMC_CEIL(`DMC_T_RP_NS)
`define DMC_RASLO_CYC `DMC_CEIL(`DMC_T_RC_NS - `DMC_T_RP_NS)
`define DMC_COL_CYC (`DMC_CEIL(`DMC_T_CAC_NS) + `DMC_SYNC_LAT)
`define DMC_CP_CYC `DMC_CEIL(`DMC_T_CP_NS)
`define DMC_REF_CYC (`DMC_T_REF_NS / `DMC_REF_ROWS / `DMC_CLK_NS)
`define DMC_PWRUP_CYC `DMC_CEIL(`DMC_T_PWRUP_NS)
`define DMC_PAGE_MAX_CYC (`DMC_T_RAS_MAX_NS / `DMC_CLK_NS - `DMC_PAGE_MARGIN)

`define DMC_ROW_HI 15
`define DMC_ROW_LO 8
`define DMC_COL_HI 7
`define DMC_COL_LO 0
`define DMC_BIT9 8

`endif

// >>> verilog/dmc_pkg.sv
// types shared by the dram host controller
// assumes nothing beyond a SystemVerilog tool
package dmc_pkg;
  typedef enum logic [2:0] {
    ST_PWR, ST_IDLE, ST_REF, ST_PRE, ST_ROW, ST_ADR, ST_COL, ST_CHI
  } dmc_state_t;
  typedef logic [15:0] dmc_addr_t;
  typedef logic [8:0] dmc_word_t;
  typedef logic [7:0] dmc_lane_t;
  typedef logic [12:0] dmc_tmr_t;
  typedef logic [9:0] dmc_rtmr_t;
  typedef logic [8:0] dmc_pcnt_t;
  typedef logic [3:0] dmc_wcnt_t;
endpackage

// >>> verilog/dmc_host.sv
// host controller for a 64K x 9 multiplexed-address dram module
// assumes a 50 MHz clk; data pins resolved by the testbench from the output enable
//
// Notes on behaviour
// - address sent as row half, then column half
// - same-row requests reuse open row (page mode)
// - all 256 rows refreshed within 4 ms
// - refresh spread evenly, one row per slot
// - column-before-row refresh not issued here
// - hidden refresh not issued here
// - 100 us wait, then eight row cycles
// - missed refresh slot repeats eight-cycle wake-up
// - column strobe high at least precharge time
// - row-to-column delay kept within its maximum
// - cycle spacing 150 ns random, 75 page
// - write data held past column strobe fall
// - write strobe high through whole read
// - refresh drives row, column strobe high
`include "dmc_params.svh"
`timescale 1ns/10ps
`default_nettype none

module dmc_host #(
  parameter int PWRUP_CYC = `DMC_PWRUP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire dmc_pkg::dmc_addr_t req_addr,
  input wire dmc_pkg::dmc_word_t req_wdata,
  output logic rsp_valid,
  output dmc_pkg::dmc_word_t rsp_rdata,
  output logic ras_n,
  output logic cas_n,
  output logic ninth_bit_column_strobe_n,
  output logic we_n,
  output dmc_pkg::dmc_lane_t multiplexed_address,
  output dmc_pkg::dmc_lane_t data_io_lanes_o,
  output logic data_io_lanes_oe,
  input wire dmc_pkg::dmc_lane_t data_io_lanes_i,
  output logic ninth_bit_input,
  input wire logic ninth_bit_output
);
  import dmc_pkg::*;

  localparam dmc_tmr_t PWR_LD = dmc_tmr_t'(PWRUP_CYC - 1);
  localparam dmc_tmr_t RP_LD = dmc_tmr_t'(`DMC_RP_CYC - 1);
  localparam dmc_tmr_t RASLO_LD = dmc_tmr_t'(`DMC_RASLO_CYC - 1);
  localparam dmc_tmr_t COL_LD = dmc_tmr_t'(`DMC_COL_CYC - 1);
  localparam dmc_tmr_t CP_LD = dmc_tmr_t'(`DMC_CP_CYC - 1);
  localparam dmc_rtmr_t REF_LD = dmc_rtmr_t'(`DMC_REF_CYC - 1);
  localparam dmc_pcnt_t PAGE_MAX = dmc_pcnt_t'(`DMC_PAGE_MAX_CYC);
  localparam dmc_wcnt_t WAKE_N = dmc_wcnt_t'(`DMC_WAKE_CYCLES);

  dmc_state_t state_ff, nxt_state;
  dmc_tmr_t tmr_ff, nxt_tmr;
  dmc_rtmr_t ref_tmr_ff;
  dmc_lane_t ref_row_ff;
  dmc_wcnt_t wake_cnt_ff, nxt_wake_cnt;
  dmc_pcnt_t ras_lo_cnt_ff;
  dmc_addr_t addr_ff, nxt_addr;
  dmc_word_t wdata_ff, nxt_wdata;
  dmc_word_t sy1_ff, sy2_ff, sy3_ff, rd_stable_ff;
  dmc_word_t rsp_rdata_ff;
  dmc_lane_t maddr_ff, dout_ff;
  logic wr_ff, nxt_wr, have_req_ff, ref_pend_ff, nxt_pend;
  logic req_ready_ff, nxt_ready, rsp_valid_ff;
  logic ras_n_ff, cas_n_ff, ninth_bit_column_strobe_n_n_ff, we_n_ff, data_oe_ff, bit9_ff;
  logic take, ref_tick, serve, page_ok;

  // *******************************************
  // sequencing
  // *******************************************
  assign take = req_valid && req_ready_ff;
  assign ref_tick = (ref_tmr_ff == '0);
  assign serve = (nxt_state == ST_REF) && (state_ff != ST_REF);
  assign page_ok = ras_lo_cnt_ff < PAGE_MAX;
  assign nxt_addr = take ? req_addr : addr_ff;
  assign nxt_wr = take ? req_write : wr_ff;
  assign nxt_wdata = take ? req_wdata : wdata_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_tmr = (tmr_ff != '0) ? tmr_ff - 1'b1 : tmr_ff;
    unique case (state_ff)
      ST_PWR: if (tmr_ff == '0) nxt_state = ST_IDLE;
      ST_IDLE: begin
        if (take) begin
          nxt_state = ST_ROW;
        end else if (wake_cnt_ff != WAKE_N || ref_pend_ff) begin
          nxt_state = ST_REF;
          nxt_tmr = RASLO_LD;
        end
      end
      ST_REF: begin
        if (tmr_ff == '0) begin
          nxt_state = ST_PRE;
          nxt_tmr = RP_LD;
        end
      end
      ST_ROW: nxt_state = ST_ADR;
      ST_ADR: begin
        nxt_state = ST_COL;
        nxt_tmr = COL_LD;
      end
      ST_COL: begin
        if (tmr_ff == '0) begin
          nxt_state = ST_CHI;
          nxt_tmr = CP_LD;
        end
      end
      ST_CHI: begin
        if (tmr_ff == '0) begin
          if (take && req_addr[`DMC_ROW_HI:`DMC_ROW_LO] == addr_ff[`DMC_ROW_HI:`DMC_ROW_LO]) begin
            nxt_state = ST_ADR;
          end else begin
            nxt_state = ST_PRE;
            nxt_tmr = RP_LD;
          end
        end
      end
      ST_PRE: if (tmr_ff == '0) nxt_state = have_req_ff ? ST_ROW : ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_PWR;
      tmr_ff <= PWR_LD;
    end else begin
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
    end
  end

  // request capture; a row miss in page mode waits through precharge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_ff <= '0;
      wr_ff <= 1'b0;
      wdata_ff <= '0;
      have_req_ff <= 1'b0;
    end else begin
      addr_ff <= nxt_addr;
      wr_ff <= nxt_wr;
      wdata_ff <= nxt_wdata;
      if (take && state_ff == ST_CHI && nxt_state == ST_PRE) begin
        have_req_ff <= 1'b1;
      end else if (state_ff == ST_PRE && nxt_state == ST_ROW) begin
        have_req_ff <= 1'b0;
      end
    end
  end

  // *******************************************
  // refresh and wake-up
  // *******************************************
  assign nxt_pend = ref_tick || (ref_pend_ff && !serve);

  always_comb begin
    nxt_wake_cnt = wake_cnt_ff;
    if (ref_tick && ref_pend_ff) begin
      nxt_wake_cnt = '0;
    end else if (serve && wake_cnt_ff != WAKE_N) begin
      nxt_wake_cnt = wake_cnt_ff + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ref_tmr_ff <= REF_LD;
      ref_pend_ff <= 1'b0;
      ref_row_ff <= '0;
      wake_cnt_ff <= '0;
    end else begin
      // slot timer parked during power-up so no refresh queues behind the wait
      ref_tmr_ff <= (ref_tick || state_ff == ST_PWR) ? REF_LD : ref_tmr_ff - 1'b1;
      ref_pend_ff <= nxt_pend;
      wake_cnt_ff <= nxt_wake_cnt;
      if (serve) ref_row_ff <= ref_row_ff + 1'b1;
    end
  end

  // bounds how long one row may stay open under page mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ras_lo_cnt_ff <= '0;
    end else if (ras_n_ff) begin
      ras_lo_cnt_ff <= '0;
    end else if (page_ok) begin
      ras_lo_cnt_ff <= ras_lo_cnt_ff + 1'b1;
    end
  end

  // *******************************************
  // pins, registered from the next state
  // *******************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ras_n_ff <= 1'b1;
      cas_n_ff <= 1'b1;
      ninth_bit_column_strobe_n_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      data_oe_ff <= 1'b0;
      maddr_ff <= '0;
      dout_ff <= '0;
      bit9_ff <= 1'b0;
    end else begin
      ras_n_ff <= !(nxt_state inside {ST_REF, ST_ROW, ST_ADR, ST_COL, ST_CHI});
      cas_n_ff <= nxt_state != ST_COL;
      ninth_bit_column_strobe_n_n_ff <= nxt_state != ST_COL;
      we_n_ff <= !(nxt_wr && nxt_state inside {ST_ROW, ST_ADR, ST_COL});
      data_oe_ff <= nxt_wr && nxt_state inside {ST_ADR, ST_COL};
      dout_ff <= nxt_wdata[`DMC_COL_HI:`DMC_COL_LO];
      bit9_ff <= nxt_wdata[`DMC_BIT9];
      // load the refresh row once; the row counter has already moved on
      if (serve) begin
        maddr_ff <= ref_row_ff;
      end else if (nxt_state == ST_ROW) begin
        maddr_ff <= nxt_addr[`DMC_ROW_HI:`DMC_ROW_LO];
      end else if (nxt_state inside {ST_ADR, ST_COL}) begin
        maddr_ff <= nxt_addr[`DMC_COL_HI:`DMC_COL_LO];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_ready_ff <= 1'b0;
    end else begin
      req_ready_ff <= nxt_ready;
    end
  end

  assign nxt_ready = !nxt_pend && nxt_wake_cnt == WAKE_N &&
                     (nxt_state == ST_IDLE ||
                      (nxt_state == ST_CHI && nxt_tmr == '0 && page_ok));

  // *******************************************
  // read data: sync, settle, answer
  // *******************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sy1_ff <= '0;
      sy2_ff <= '0;
      sy3_ff <= '0;
      rd_stable_ff <= '0;
    end else begin
      sy1_ff <= {ninth_bit_output, data_io_lanes_i};
      sy2_ff <= sy1_ff;
      sy3_ff <= sy2_ff;
      if (sy2_ff == sy3_ff) rd_stable_ff <= sy3_ff;
    end
  end

  // column strobe stays low long enough to cover access time plus sync delay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_valid_ff <= 1'b0;
      rsp_rdata_ff <= '0;
    end else begin
      rsp_valid_ff <= state_ff == ST_COL && tmr_ff == '0 && !wr_ff;
      if (state_ff == ST_COL && tmr_ff == '0 && !wr_ff) rsp_rdata_ff <= rd_stable_ff;
    end
  end

  assign req_ready = req_ready_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_rdata = rsp_rdata_ff;
  assign ras_n = ras_n_ff;
  assign cas_n = cas_n_ff;
  assign ninth_bit_column_strobe_n = ninth_bit_column_strobe_n_n_ff;
  assign we_n = we_n_ff;
  assign multiplexed_address = maddr_ff;
  assign data_io_lanes_o = dout_ff;
  assign data_io_lanes_oe = data_oe_ff;
  assign ninth_bit_input = bit9_ff;

  // *******************************************
  // assertions
  // *******************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_row_open;
    state_ff == ST_ROW && $fell(ras_n_ff);
  endsequence
  sequence s_col_fall;
    $fell(cas_n_ff) && multiplexed_address == addr_ff[`DMC_COL_HI:`DMC_COL_LO];
  endsequence
  property p_row_col;
    s_row_open |-> maddr_ff == addr_ff[`DMC_ROW_HI:`DMC_ROW_LO] ##2 s_col_fall;
  endproperty
  a_row_col: assert property (p_row_col) else $error("row then column order broken");
  property p_early_wr;
    ($fell(cas_n_ff) && !we_n_ff) |-> $past(!we_n_ff) && data_oe_ff ##1 data_oe_ff;
  endproperty
  a_early_wr: assert property (p_early_wr) else $error("early write timing broken");
  property p_rd_we;
    (!cas_n_ff && we_n_ff && !ras_n_ff) |=> we_n_ff;
  endproperty
  a_rd_we: assert property (p_rd_we) else $error("write strobe fell during read");
  property p_prech;
    $rose(ras_n_ff) |-> ras_n_ff[*3];
  endproperty
  a_prech: assert property (p_prech) else $error("row precharge too short");
  property p_cas_hi;
    ($rose(cas_n_ff) && !ras_n_ff) |-> cas_n_ff[*2];
  endproperty
  a_cas_hi: assert property (p_cas_hi) else $error("column precharge too short");
  property p_ref_only;
    state_ff == ST_REF |-> !ras_n_ff && cas_n_ff && maddr_ff == 8'(ref_row_ff - 8'h01);
  endproperty
  a_ref_only: assert property (p_ref_only) else $error("refresh pin state wrong");
  property p_wake;
    req_ready_ff |-> wake_cnt_ff == WAKE_N && state_ff != ST_PWR;
  endproperty
  a_wake: assert property (p_wake) else $error("access before wake-up done");
  property p_ref_served;
    $rose(ref_pend_ff) |-> ##[1:40] !ref_pend_ff;
  endproperty
  a_ref_served: assert property (p_ref_served) else $error("refresh not served");
  property p_miss;
    (ref_tick && ref_pend_ff) |=> wake_cnt_ff == '0 && !req_ready_ff;
  endproperty
  a_miss: assert property (p_miss) else $error("missed refresh did not restart wake");
  property p_rsp;
    ($fell(cas_n_ff) && we_n_ff) |-> ##6 rsp_valid_ff;
  endproperty
  a_rsp: assert property (p_rsp) else $error("read answer late or missing");
endmodule

`default_nettype wire

// >>> tb/dmc_dram_model.sv
// device model: 64K x 9 multiplexed-address dram on strobes
// assumes the bench merges the shared lanes using the controller's enable only
`timescale 1ns/10ps
`default_nettype none
module dmc_dram_model (
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic ninth_bit_column_strobe_n,
  input wire logic we_n,
  input wire logic [7:0] multiplexed_address,
  input wire logic [7:0] data_io_lanes,
  input wire logic ninth_bit_input,
  output logic [7:0] q,
  output logic ninth_bit_output
);
  logic [8:0] mem [65536];
  logic [7:0] row, col, col9;
  logic cbr = 1'b0;
  initial q = 8'h5a;
  initial ninth_bit_output = 1'b0;
  // ****
  // strobes, sampled just after each falling edge
  // ****
  always @(negedge ras_n) begin
    #1;
    cbr = !cas_n;
    if (!cbr) row = multiplexed_address;
  end
  always @(posedge ras_n) cbr = 1'b0;
  always @(negedge cas_n) begin
    #1;
    col = multiplexed_address;
    if (!ras_n && !cbr && !we_n) mem[{row, col}][7:0] = data_io_lanes;
    else if (!ras_n && !cbr) #29 q = mem[{row, col}][7:0];
  end
  // a floated lane shows the inverse, never a stale copy
  always @(posedge cas_n) q = ~q;
  always @(negedge ninth_bit_column_strobe_n) begin
    #1;
    col9 = multiplexed_address;
    if (!ras_n && !cbr && !we_n) mem[{row, col9}][8] = ninth_bit_input;
    else if (!ras_n && !cbr) #29 ninth_bit_output = mem[{row, col9}][8];
  end
  always @(posedge ninth_bit_column_strobe_n) ninth_bit_output = ~ninth_bit_output;
endmodule
`default_nettype wire

// >>> tb/dmc_host_tb.sv
// self-checking bench for the dram host controller
// assumes dmc_dram_model on the pins and a short power-up wait
`timescale 1ns/10ps
`default_nettype none
module dmc_host_tb;
  import dmc_pkg::*;
  logic clk, rst, req_valid, req_write, req_ready, rsp_valid;
  logic ras_n, cas_n, nb_cas_n, we_n, oe, b9_in, b9_q;
  logic saw_cas = 1'b0, have_ref = 1'b0;
  dmc_addr_t req_addr, cur_addr, a;
  dmc_word_t req_wdata, rsp_rdata, cur_wdata;
  dmc_lane_t maddr, lanes_o, lanes_i, m_q, row_l, ref_row;
  int n_fail = 0, total_checks = 0, n_ras = 0, i;
  realtime t_ras = -1e6, t_rise = -1e6, t_cas = -1e6, t_crise = -1e6, t_ref, t_rel;
  dmc_word_t mem_exp [dmc_addr_t];
  dmc_addr_t used [$];
  dmc_addr_t ca [4] = '{16'h0000, 16'hffff, 16'h00ff, 16'hff00};
  dmc_word_t cd [4] = '{9'h1ff, 9'h000, 9'h155, 9'h0aa};

  dmc_host #(.PWRUP_CYC(50)) DUT (
    .clk(clk), .rst(rst), .req_valid(req_valid), .req_ready(req_ready),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ras_n(ras_n), .cas_n(cas_n),
    .ninth_bit_column_strobe_n(nb_cas_n), .we_n(we_n), .multiplexed_address(maddr),
    .data_io_lanes_o(lanes_o), .data_io_lanes_oe(oe), .data_io_lanes_i(lanes_i),
    .ninth_bit_input(b9_in), .ninth_bit_output(b9_q));
  dmc_dram_model u_dram (
    .ras_n(ras_n), .cas_n(cas_n), .ninth_bit_column_strobe_n(nb_cas_n), .we_n(we_n),
    .multiplexed_address(maddr), .data_io_lanes(lanes_i), .ninth_bit_input(b9_in),
    .q(m_q), .ninth_bit_output(b9_q));
  // controller wins the shared lanes while it drives them
  assign lanes_i = oe ? lanes_o : m_q;
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ****
  // checking and closing
  // ****
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done;
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic give_up;
    n_fail++;
    test_done;
  endtask
  task automatic wait_ready;
    int k;
    for (k = 0; k < 3000 && req_ready !== 1'b1; k++) @(negedge clk);
    if (k == 3000) give_up;
  endtask
  task automatic idle_chk;
    chk("idle pins", {ras_n, cas_n, nb_cas_n, we_n, oe, req_ready, rsp_valid}, 7'h78);
  endtask
  task automatic release_rst;
    rst = 1'b0;
    t_rel = $realtime;
    n_ras = 0;
    have_ref = 1'b0;
  endtask
  task automatic xfer(input logic w, input dmc_addr_t ad, input dmc_word_t d);
    int k;
    @(negedge clk);
    req_valid = 1'b1;
    req_write = w;
    req_addr = ad;
    req_wdata = d;
    wait_ready;
    @(posedge clk);
    cur_addr = ad;
    cur_wdata = d;
    // ready is low after a take, so holding valid to the falling edge is harmless
    @(negedge clk);
    req_valid = 1'b0;
    if (w) begin
      mem_exp[ad] = d;
      used.push_back(ad);
    end else begin
      for (k = 0; k < 3000 && rsp_valid !== 1'b1; k++) @(negedge clk);
      if (k == 3000) give_up;
      chk("read data", rsp_rdata, mem_exp[ad]);
    end
  endtask
  // ****
  // pin monitors
  // ****
  always @(negedge ras_n) begin
    #1;
    row_l = maddr;
    saw_cas = 1'b0;
    // one cycle of slack for the release edge
    if (n_ras == 0) chk("power-up wait", $realtime - t_rel >= 980, 1);
    chk("ras period", $realtime - t_ras >= 150, 1);
    chk("ras precharge", $realtime - t_rise >= 60, 1);
    n_ras++;
    t_ras = $realtime;
  end
  always @(posedge ras_n) begin
    t_rise = $realtime;
    if (!saw_cas && !rst) begin
      if (have_ref) chk("refresh row", row_l, 8'(ref_row + 8'h01));
      // one slot of 781 cycles plus at most 40 cycles of service delay
      if (have_ref) chk("refresh gap", t_ras - t_ref <= 16420, 1);
      have_ref = 1'b1;
      ref_row = row_l;
      t_ref = t_ras;
    end
  end
  always @(posedge cas_n) t_crise = $realtime;
  always @(negedge we_n) begin
    #1;
    chk("early write", cas_n, 1'b1);
  end
  always @(negedge cas_n) begin
    #1;
    chk("ninth strobe", nb_cas_n, 1'b0);
    chk("row then column", {row_l, maddr}, cur_addr);
    chk("cas precharge", $realtime - t_crise >= 25, 1);
    chk("page cycle", $realtime - t_cas >= 75, 1);
    if (!saw_cas) chk("ras to cas", $realtime - t_ras <= 40, 1);
    saw_cas = 1'b1;
    t_cas = $realtime;
    if (!we_n) begin
      chk("write data", {oe, b9_in, lanes_o}, {1'b1, cur_wdata});
      #15;
      chk("write hold", {oe, b9_in, lanes_o}, {1'b1, cur_wdata});
    end
  end
  // ****
  // main sequence
  // ****
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 16'h0000;
    req_wdata = 9'h000;
    void'($urandom(37014));
    repeat (16) @(negedge clk);
    idle_chk;
    release_rst;
    wait_ready;
    chk("wake-up cycles", n_ras >= 8, 1);
    for (i = 0; i < 4; i++) xfer(1'b1, ca[i], cd[i]);
    for (i = 0; i < 4; i++) xfer(1'b0, ca[i], 9'h000);
    // few rows, so page hits and row misses both occur
    for (i = 0; i < 80; i++) begin
      a = {8'($urandom % 3), 8'($urandom)};
      if ($urandom % 2) xfer(1'b0, used[$urandom % used.size()], 9'h000);
      else xfer(1'b1, a, 9'($urandom));
      repeat ($urandom % 3) @(negedge clk);
      if (i % 20 == 19) repeat (2000) @(negedge clk);
    end
    repeat (20) @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    idle_chk;
    release_rst;
    wait_ready;
    chk("wake-up again", n_ras >= 8, 1);
    for (i = 0; i < 4; i++) xfer(1'b0, ca[i], 9'h000);
    test_done;
  end
endmodule
`default_nettype wire
